// >>> verilog/dcs_top.sv
// Purpose: picks one serial stream and its clock for the display
// Assumes: select lines and serial pins are asynchronous to REF_CLK
// Notes: one display bit takes two cycles; faster streams overrun
`include "dcs_consts.svh"

// Functional notes
// - no revertive clock: use control clock instead
// - revertive inhibit input blocks revertive data
// - display data leaves in inverted polarity
// - external data only while entry enable asserted
// - check select routes revertive highway data
// - in select routes transfer highway data
// - recall select routes recall store data
// - each source travels with its own clock, external data with the control clock
// - encoder on six selects steers paired mux
// - levels: external 1, check 3, in 5, preserve 6
// - highest active select wins, recall on top
// - preserve overrides check and in, inhibits output
module dcs_top
  import dcs_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic REV_CLK,
  input wire logic REV_DATA,
  input wire logic REV_INHIBIT,
  input wire logic CTL_CLK,
  input wire logic CTL_DATA,
  input wire logic EXT_DATA,
  input wire logic XFER_CLK,
  input wire logic XFER_DATA,
  input wire logic EXT_ENTRY_EN,
  input wire logic EXT_SEL,
  input wire logic CHECK_SEL,
  input wire logic IN_SEL,
  input wire logic PRESERVE_SEL,
  input wire logic RECALL_SEL,
  input wire logic DISP_READY,
  output logic DISP_DATA,
  output logic DISP_CLK,
  output logic [2:0] SEL_LEVEL,
  output logic REV_CLK_LOST,
  output logic OVERRUN
);

  localparam int LOSS_LIM = `DCS_REV_LOSS_CYC;

  dcs_ref_st_t r_reg, r_next;
  dcs_link_st_t l_reg, l_next;
  dcs_pins_t pins;
  logic ctl_rise, xfer_rise, rev_take, rev_bit;
  logic src_ev, src_bit, routing, flush;
  logic buf_in_ready, buf_out_valid, buf_out_ready, buf_out_data;

  // ----------------------------------------------------------------
  // link side: revertive bits land in a four-slot ring
  // ----------------------------------------------------------------
  // gray pointer crosses to REF_CLK; a slot stays put for four bits
  always_comb begin
    l_next = l_reg;
    l_next.slot[l_reg.wp] = REV_DATA;
    l_next.wp = l_reg.wp ^ ((^l_reg.wp) ? 2'h2 : 2'h1);
  end

  always_ff @(posedge REV_CLK or posedge RST) begin
    if (RST) begin
      l_reg <= '0;
    end else begin
      l_reg <= l_next;
    end
  end

  // ----------------------------------------------------------------
  // pin capture and edge detection
  // ----------------------------------------------------------------
  always_comb begin
    pins.ext_en = EXT_ENTRY_EN;
    pins.ext_sel = EXT_SEL;
    pins.check = CHECK_SEL;
    pins.in_sel = IN_SEL;
    pins.preserve = PRESERVE_SEL;
    pins.recall = RECALL_SEL;
    pins.rev_inh = REV_INHIBIT;
    pins.rev_data = REV_DATA;
    pins.ctl_clk = CTL_CLK;
    pins.ctl_data = CTL_DATA;
    pins.ext_data = EXT_DATA;
    pins.xfer_clk = XFER_CLK;
    pins.xfer_data = XFER_DATA;
  end

  assign ctl_rise = r_reg.s2.ctl_clk & ~r_reg.ctl_clk_d;
  assign xfer_rise = r_reg.s2.xfer_clk & ~r_reg.xfer_clk_d;
  assign rev_take = (r_reg.rd_ptr != r_reg.gp2);
  assign rev_bit = l_reg.slot[r_reg.rd_ptr];

  // ----------------------------------------------------------------
  // source mux: data and clock chosen as a pair
  // ----------------------------------------------------------------
  assign routing = (r_reg.sel == DCS_S_EXT) || (r_reg.sel == DCS_S_REV) ||
                   (r_reg.sel == DCS_S_XFER) || (r_reg.sel == DCS_S_RECALL);

  always_comb begin
    src_ev = 1'h0;
    src_bit = 1'h0;
    case (r_reg.sel)
      DCS_S_EXT: begin
        src_ev = ctl_rise & r_reg.s2.ext_en;
        src_bit = r_reg.s2.ext_data;
      end
      DCS_S_REV: begin
        // a returning revertive bit takes the ring path, or it is lost
        if (r_reg.lost && !rev_take) begin
          src_ev = ctl_rise & ~r_reg.s2.rev_inh;
          src_bit = r_reg.s2.rev_data;
        end else begin
          src_ev = rev_take & ~r_reg.s2.rev_inh;
          src_bit = rev_bit;
        end
      end
      DCS_S_XFER: begin
        src_ev = xfer_rise;
        src_bit = r_reg.s2.xfer_data;
      end
      DCS_S_RECALL: begin
        src_ev = ctl_rise;
        src_bit = r_reg.s2.ctl_data;
      end
      default: begin
        src_ev = 1'h0;
        src_bit = 1'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.s1 = pins;
    r_next.s2 = r_reg.s1;
    r_next.ctl_clk_d = r_reg.s2.ctl_clk;
    r_next.xfer_clk_d = r_reg.s2.xfer_clk;
    r_next.gp1 = l_reg.wp;
    r_next.gp2 = r_reg.gp1;
    r_next.ovr = 1'h0;
    // ring slots are read even when discarded, so the pointer follows
    if (rev_take) begin
      r_next.rd_ptr = r_reg.rd_ptr ^ ((^r_reg.rd_ptr) ? 2'h2 : 2'h1);
    end
    // absence watchdog on the revertive clock
    if (rev_take) begin
      r_next.loss_cnt = 8'h00;
      r_next.lost = 1'h0;
    end else if (r_reg.loss_cnt == 8'(LOSS_LIM - 1)) begin
      r_next.lost = 1'h1;
    end else begin
      r_next.loss_cnt = r_reg.loss_cnt + 8'h01;
    end
    // priority encoder, highest level first
    if (r_reg.s2.recall) begin
      r_next.sel = DCS_S_RECALL;
      r_next.lvl = `DCS_LVL_RECALL;
    end else if (r_reg.s2.preserve) begin
      r_next.sel = DCS_S_HOLD;
      r_next.lvl = `DCS_LVL_PRESERVE;
    end else if (r_reg.s2.in_sel) begin
      r_next.sel = DCS_S_XFER;
      r_next.lvl = `DCS_LVL_IN;
    end else if (r_reg.s2.check) begin
      r_next.sel = DCS_S_REV;
      r_next.lvl = `DCS_LVL_CHECK;
    end else if (r_reg.s2.ext_en || r_reg.s2.ext_sel) begin
      r_next.sel = DCS_S_EXT;
      r_next.lvl = `DCS_LVL_EXT;
    end else begin
      r_next.sel = DCS_S_IDLE;
      r_next.lvl = `DCS_LVL_NONE;
    end
    // capture stage stalls on a full buffer; a bit arriving then is lost
    if (src_ev) begin
      if (r_reg.pend_v && !buf_in_ready) begin
        r_next.ovr = 1'h1;
      end else begin
        r_next.pend_v = 1'h1;
        r_next.pend_b = ~src_bit;
      end
    end else if (buf_in_ready) begin
      r_next.pend_v = 1'h0;
    end
    // serializer: data set first, clock high one cycle later
    // an empty buffer must not start a clock pulse
    if (buf_out_ready && buf_out_valid) begin
      r_next.ddat = buf_out_data;
      r_next.dclk = 1'h0;
      r_next.phase = 1'h1;
    end else if (r_reg.phase) begin
      r_next.dclk = 1'h1;
      r_next.phase = 1'h0;
    end else begin
      r_next.dclk = 1'h0;
    end
    // a change of source drops whatever the old source left behind
    // selection compared here, not through flush, so no loop forms
    if ((r_next.sel != r_reg.sel) || !routing) begin
      r_next.pend_v = 1'h0;
      r_next.phase = 1'h0;
      r_next.dclk = `DCS_IDLE_CLK;
      r_next.ddat = `DCS_IDLE_DATA;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      r_reg <= '0;
      r_reg.sel <= DCS_S_IDLE;
      r_reg.ddat <= `DCS_IDLE_DATA;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // buffer between capture and display
  // ----------------------------------------------------------------
  assign flush = (r_next.sel != r_reg.sel);
  assign buf_out_ready = routing & DISP_READY & ~r_reg.phase;

  dcs_buf #(
    .W(1)
  ) u_buf (
    .clk(REF_CLK),
    .rst(RST),
    .flush(flush),
    .in_valid(r_reg.pend_v),
    .in_ready(buf_in_ready),
    .in_data(r_reg.pend_b),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready & buf_out_valid),
    .out_data(buf_out_data)
  );

  assign DISP_DATA = r_reg.ddat;
  assign DISP_CLK = r_reg.dclk;
  assign SEL_LEVEL = r_reg.lvl;
  assign REV_CLK_LOST = r_reg.lost;
  assign OVERRUN = r_reg.ovr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  a_rev_loss_sub: assert property (
    (r_reg.loss_cnt == 8'(LOSS_LIM - 1)) && !rev_take |=> REV_CLK_LOST)
    else $error("revertive clock loss not flagged");

  a_rev_inh_block: assert property (
    r_reg.s2.rev_inh && (r_reg.sel == DCS_S_REV) |-> !src_ev)
    else $error("revertive bit passed while inhibited");

  a_data_inv: assert property (
    src_ev && !(r_reg.pend_v && !buf_in_ready) |=>
      r_reg.pend_b == !$past(src_bit))
    else $error("display bit not inverted");

  a_ext_gate: assert property (
    src_ev && (r_reg.sel == DCS_S_EXT) |-> r_reg.s2.ext_en)
    else $error("external data passed without entry enable");

  a_check_route: assert property (
    (r_reg.sel == DCS_S_REV) && !r_reg.lost && rev_take &&
      !r_reg.s2.rev_inh |-> src_ev && (src_bit == rev_bit))
    else $error("revertive highway not routed");

  a_in_route: assert property (
    (r_reg.sel == DCS_S_XFER) |->
      (src_ev == xfer_rise) && (src_bit == r_reg.s2.xfer_data))
    else $error("transfer highway not routed");

  a_recall_route: assert property (
    (r_reg.sel == DCS_S_RECALL) |->
      (src_ev == ctl_rise) && (src_bit == r_reg.s2.ctl_data))
    else $error("recall data not routed");

  a_clk_pair_sub: assert property (
    (r_reg.sel == DCS_S_REV) && r_reg.lost && !r_reg.s2.rev_inh &&
      !rev_take |-> src_ev == ctl_rise)
    else $error("control clock not substituted");

  a_lvl_map: assert property (
    (r_reg.sel == DCS_S_XFER) |-> SEL_LEVEL == `DCS_LVL_IN)
    else $error("in select level wrong");

  a_recall_wins: assert property (
    r_reg.s2.recall |=> (r_reg.sel == DCS_S_RECALL) &&
      (SEL_LEVEL == `DCS_LVL_RECALL))
    else $error("recall did not win");

  a_preserve_hold: assert property (
    r_reg.s2.preserve && !r_reg.s2.recall [*2] |->
      (r_reg.sel == DCS_S_HOLD) && !src_ev ##1 !DISP_CLK)
    else $error("preserve did not inhibit output");

  a_ext_lowest: assert property (
    r_reg.s2.check && !r_reg.s2.in_sel && !r_reg.s2.preserve &&
      !r_reg.s2.recall |=> (r_reg.sel == DCS_S_REV))
    else $error("check lost to a lower select");

  a_idle_levels: assert property (
    (r_reg.sel == DCS_S_IDLE) [*2] |->
      (DISP_CLK == `DCS_IDLE_CLK) && (DISP_DATA == `DCS_IDLE_DATA))
    else $error("outputs not idle without a select");

  a_no_empty_clk: assert property (
    !buf_out_valid && !r_reg.phase |=> !r_reg.phase)
    else $error("display clock started without a bit");

  a_clk_pulse: assert property (
    DISP_CLK |=> !DISP_CLK)
    else $error("display clock high for more than a cycle");

  a_lvl_check: assert property (
    (r_reg.sel == DCS_S_REV) |-> SEL_LEVEL == `DCS_LVL_CHECK)
    else $error("check select level wrong");

  c_recall_bit: cover property (
    (r_reg.sel == DCS_S_RECALL) && src_ev ##[1:8] DISP_CLK);
  c_rev_subst: cover property (
    (r_reg.sel == DCS_S_REV) && r_reg.lost && src_ev);
  c_stall_fill: cover property (!DISP_READY && !buf_in_ready);
  c_overrun: cover property (OVERRUN);

endmodule

// >>> pkg/dcs_consts.svh
// Purpose: constants of the display data and clock selector
// Assumes: reference clock of 20 MHz
// Notes: times in ns, cycle counts derived from them
`ifndef DCS_CONSTS_SVH
`define DCS_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DCS_REF_PERIOD_NS 50
`define DCS_REV_LOSS_NS 10000
// least time without a revertive bit, rounded up to whole cycles
`define DCS_REV_LOSS_CYC \
  ((`DCS_REV_LOSS_NS + `DCS_REF_PERIOD_NS - 1) / `DCS_REF_PERIOD_NS)

// ----------------------------------------------------------------
// encoder levels and idle levels
// ----------------------------------------------------------------
`define DCS_LVL_NONE 3'h0
`define DCS_LVL_EXT 3'h1
`define DCS_LVL_CHECK 3'h3
`define DCS_LVL_IN 3'h5
`define DCS_LVL_PRESERVE 3'h6
`define DCS_LVL_RECALL 3'h7
`define DCS_IDLE_DATA 1'h1
`define DCS_IDLE_CLK 1'h0

`endif

// >>> pkg/dcs_pkg.sv
// Purpose: types of the display data and clock selector
// Assumes: nothing
// Notes: selector state is one-hot
package dcs_pkg;

  typedef enum logic [5:0] {
    DCS_S_IDLE = 6'h01,
    DCS_S_EXT = 6'h02,
    DCS_S_REV = 6'h04,
    DCS_S_XFER = 6'h08,
    DCS_S_HOLD = 6'h10,
    DCS_S_RECALL = 6'h20
  } dcs_sel_t;

  typedef struct packed {
    logic ext_en;
    logic ext_sel;
    logic check;
    logic in_sel;
    logic preserve;
    logic recall;
    logic rev_inh;
    logic rev_data;
    logic ctl_clk;
    logic ctl_data;
    logic ext_data;
    logic xfer_clk;
    logic xfer_data;
  } dcs_pins_t;

  typedef struct packed {
    dcs_pins_t s1;
    dcs_pins_t s2;
    logic ctl_clk_d;
    logic xfer_clk_d;
    logic [1:0] gp1;
    logic [1:0] gp2;
    logic [1:0] rd_ptr;
    logic [7:0] loss_cnt;
    logic lost;
    dcs_sel_t sel;
    logic pend_v;
    logic pend_b;
    logic phase;
    logic dclk;
    logic ddat;
    logic ovr;
    logic [2:0] lvl;
  } dcs_ref_st_t;

  typedef struct packed {
    logic [1:0] wp;
    logic [3:0] slot;
  } dcs_link_st_t;

endpackage

// >>> verilog/dcs_buf.sv
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: one clock, asynchronous active-high reset
// Notes: read data come straight from the head register
module dcs_buf #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  typedef struct packed {
    logic [1:0] cnt;
    logic [W-1:0] e0;
    logic [W-1:0] e1;
  } dcs_buf_st_t;

  dcs_buf_st_t r_reg, r_next;
  logic push, pop;

  assign in_ready = (r_reg.cnt != 2'h2);
  assign out_valid = (r_reg.cnt != 2'h0);
  assign out_data = r_reg.e0;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // full refuses a push even with a pop, keeping ready free of out_ready
  always_comb begin
    r_next = r_reg;
    if (push && pop) begin
      if (r_reg.cnt == 2'h1) begin
        r_next.e0 = in_data;
      end else begin
        r_next.e0 = r_reg.e1;
        r_next.e1 = in_data;
      end
    end else if (pop) begin
      r_next.e0 = r_reg.e1;
      r_next.cnt = r_reg.cnt - 2'h1;
    end else if (push) begin
      if (r_reg.cnt == 2'h0) begin
        r_next.e0 = in_data;
      end else begin
        r_next.e1 = in_data;
      end
      r_next.cnt = r_reg.cnt + 2'h1;
    end
    if (flush) begin
      r_next.cnt = 2'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

// >>> verif/dcs_disp_model.sv
// Purpose: display receiver model, shifts in bits on each clock pulse
// Assumes: same REF_CLK domain as the selector
// Notes: ready follows stall one cycle late, as a real register would
module dcs_disp_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic disp_data,
  input wire logic disp_clk,
  output logic disp_ready,
  output logic [7:0] rx_bits,
  output logic [7:0] rx_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // capture
  // --------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      disp_ready <= 1'h1;
      rx_bits <= 8'h00;
      rx_cnt <= 8'h00;
    end else begin
      disp_ready <= ~stall;
      if (disp_clk === 1'h1) begin
        rx_bits <= {rx_bits[6:0], disp_data};
        rx_cnt <= rx_cnt + 8'h01;
      end
    end
  end
endmodule

// >>> verif/dcs_top_tb.sv
// Purpose: self-checking bench of the display data and clock selector
// Assumes: frame sources run well below one bit per two cycles; revertive bursts run faster
// Notes: control clock pulses for three bits only, so pairing shows
`include "dcs_consts.svh"
module dcs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [3:0] P_CTL = 4'h9;
  localparam logic [3:0] P_XFR = 4'h6;
  localparam logic [3:0] P_EXT = 4'hc;
  localparam logic [3:0] P_REV = 4'h3;
  logic clk = 1'h0, rst = 1'h1, stall = 1'h0;
  logic rev_clk = 1'h0, rev_d = 1'h0, rev_inh = 1'h0;
  logic ctl_clk = 1'h0, ctl_d = 1'h0, ext_d = 1'h0;
  logic xfer_clk = 1'h0, xfer_d = 1'h0;
  logic [5:0] sel = 6'h00;
  logic dd, dclk, lost, ovr, rdy;
  logic [2:0] lvl;
  logic [7:0] rx_bits, rx_cnt, n0, ov_cnt = 8'h00, ov0;
  int miscompares = 0, checks_done = 0;
  // rows: ext_en ext_sel check in preserve recall, level, count, bits
  logic [15:0] rows [11] = '{
    {6'h00, `DCS_LVL_NONE, 3'h0, 4'h0},
    {6'h20, `DCS_LVL_EXT, 3'h3, {1'h0, ~P_EXT[3:1]}},
    {6'h10, `DCS_LVL_EXT, 3'h0, 4'h0},
    {6'h08, `DCS_LVL_CHECK, 3'h4, ~P_REV},
    {6'h04, `DCS_LVL_IN, 3'h4, ~P_XFR},
    {6'h0c, `DCS_LVL_IN, 3'h4, ~P_XFR},
    {6'h06, `DCS_LVL_PRESERVE, 3'h0, 4'h0},
    {6'h0a, `DCS_LVL_PRESERVE, 3'h0, 4'h0},
    {6'h01, `DCS_LVL_RECALL, 3'h3, {1'h0, ~P_CTL[3:1]}},
    {6'h3f, `DCS_LVL_RECALL, 3'h3, {1'h0, ~P_CTL[3:1]}},
    {6'h28, `DCS_LVL_CHECK, 3'h4, ~P_REV}};

  dcs_top i_dcs_top (.REF_CLK(clk), .RST(rst), .REV_CLK(rev_clk),
    .REV_DATA(rev_d), .REV_INHIBIT(rev_inh), .CTL_CLK(ctl_clk),
    .CTL_DATA(ctl_d), .EXT_DATA(ext_d), .XFER_CLK(xfer_clk),
    .XFER_DATA(xfer_d), .EXT_ENTRY_EN(sel[5]), .EXT_SEL(sel[4]),
    .CHECK_SEL(sel[3]), .IN_SEL(sel[2]), .PRESERVE_SEL(sel[1]),
    .RECALL_SEL(sel[0]), .DISP_READY(rdy), .DISP_DATA(dd),
    .DISP_CLK(dclk), .SEL_LEVEL(lvl), .REV_CLK_LOST(lost),
    .OVERRUN(ovr));
  dcs_disp_model i_dcs_disp_model (.clk(clk), .rst(rst), .stall(stall),
    .disp_data(dd), .disp_clk(dclk), .disp_ready(rdy),
    .rx_bits(rx_bits), .rx_cnt(rx_cnt));

  // --------------------------------------------------------------
  // clock, overrun tally, watchdog
  // --------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (ovr === 1'h1) ov_cnt <= ov_cnt + 8'h01;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // link clock at 64 ns, stands still outside the burst
  task automatic rev_burst(input logic [3:0] b);
    #7;
    for (int i = 3; i >= 0; i--) begin
      rev_d = b[i];
      #16 rev_clk = 1'h1;
      #32 rev_clk = 1'h0;
      #16;
    end
    rev_d = ~rev_d;
  endtask
  // each clock high 3 and low 4 cycles, data set a cycle ahead
  task automatic frame(input logic [3:0] x, r);
    for (int i = 3; i >= 0; i--) begin
      @(posedge clk);
      ctl_d <= P_CTL[i];
      xfer_d <= x[i];
      ext_d <= P_EXT[i];
      rev_d <= r[i];
      @(posedge clk);
      xfer_clk <= 1'h1;
      ctl_clk <= (i > 0);
      repeat (3) @(posedge clk);
      xfer_clk <= 1'h0;
      ctl_clk <= 1'h0;
      repeat (2) @(posedge clk);
    end
    @(posedge clk);
    ctl_d <= ~ctl_d;
    xfer_d <= ~xfer_d;
    ext_d <= ~ext_d;
    repeat (25) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    logic [5:0] s;
    logic [2:0] el, en;
    logic [3:0] eb;
    repeat (3) @(posedge clk);
    chk("reset", 8'h40, {1'h0, dd, dclk, lvl, lost, ovr});
    @(posedge clk);
    rst <= 1'h0;
    for (int k = 0; k < 11; k++) begin
      {s, el, en, eb} = rows[k];
      @(posedge clk);
      sel <= s;
      rev_burst(4'ha);
      repeat (20) @(posedge clk);
      chk("level", {5'h0, el}, {5'h0, lvl});
      n0 = rx_cnt;
      rev_burst(P_REV);
      frame(P_XFR, 4'h5);
      chk("count", {5'h0, en}, rx_cnt - n0);
      chk("bits", {4'h0, eb}, rx_bits & ((8'h01 << en) - 8'h01));
      if (en == 3'h0 && el != `DCS_LVL_EXT)
        chk("idle", {6'h0, `DCS_IDLE_DATA, `DCS_IDLE_CLK}, {6'h0, dd, dclk});
      $display("row %0d done", k);
    end
    chk("no overrun", 8'h00, ov_cnt);
    // no revertive clock: control clock carries revertive data
    @(posedge clk);
    sel <= 6'h08;
    repeat (230) @(posedge clk);
    chk("lost", 8'h01, {7'h0, lost});
    n0 = rx_cnt;
    frame(P_XFR, 4'hb);
    chk("subst count", 8'h03, rx_cnt - n0);
    chk("subst bits", 8'h02, rx_bits & 8'h07);
    n0 = rx_cnt;
    rev_burst(P_REV);
    repeat (20) @(posedge clk);
    chk("regained", 8'h00, {7'h0, lost});
    chk("regained count", 8'h04, rx_cnt - n0);
    chk("regained bits", {4'h0, ~P_REV}, rx_bits & 8'h0f);
    $display("loss test done");
    // inhibit blocks revertive bits
    rev_inh <= 1'h1;
    repeat (10) @(posedge clk);
    n0 = rx_cnt;
    rev_burst(P_REV);
    repeat (30) @(posedge clk);
    chk("inhibit", 8'h00, rx_cnt - n0);
    rev_inh <= 1'h0;
    $display("inhibit test done");
    // stalled receiver: three bits kept, the fourth dropped
    sel <= 6'h04;
    stall <= 1'h1;
    repeat (10) @(posedge clk);
    n0 = rx_cnt;
    ov0 = ov_cnt;
    frame(P_XFR, 4'h5);
    stall <= 1'h0;
    repeat (20) @(posedge clk);
    chk("stall count", 8'h03, rx_cnt - n0);
    chk("stall bits", 8'h04, rx_bits & 8'h07);
    chk("overrun", 8'h01, ov_cnt - ov0);
    $display("stall test done");
    give_verdict();
  end
endmodule
